// >>> btp_payload_builder.sv
/*
 * builds the 13-byte signed data payload of a pushbutton transmitter and streams it out.
 * assumes configuration ports hold still while busy is high; pins are asynchronous.
 */
`timescale 1ns/1ps
module btp_payload_builder (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         actuate,
    input  wire logic         harvest_dir_away,
    input  wire logic         aux_contact_a_n,
    input  wire logic         aux_contact_b_n,
    input  wire logic         invert_direction,
    input  wire logic         custom_enable,
    input  wire logic         use_alternate_key,
    input  wire logic [15:0]  maker_id_field,
    input  wire logic [47:0]  source_addr,
    input  wire logic [127:0] factory_auth_key,
    input  wire logic [127:0] alternate_auth_key,
    input  wire logic         table_wr_en,
    input  wire logic [2:0]   table_wr_idx,
    input  wire logic [7:0]   custom_event_code_entry,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [7:0]        out_data,
    output logic              out_last,
    output logic              busy,
    output logic              suppressed,
    output logic              sent,
    output logic [31:0]       seq_count
);

    typedef struct packed {
        btp_pkg::btp_state_t st;
        logic [2:0]   act_sync;
        logic [2:0]   dir_sync;
        logic [2:0]   a_sync;
        logic [2:0]   b_sync;
        logic         act_filt;
        logic         act_prev;
        logic         dir_filt;
        logic         a_filt;
        logic         b_filt;
        logic         press;
        logic         aux_a;
        logic         aux_b;
        logic         key_alt;
        logic [15:0]  maker;
        logic [7:0]   code;
        logic [31:0]  seq;
        logic [127:0] aes;
        logic [127:0] rk;
        logic [7:0]   rcon;
        logic [3:0]   round;
        logic [1:0]   phase;
        logic [31:0]  tag;
        logic [31:0]  sig;
        logic [3:0]   idx;
        logic         out_valid;
        logic [7:0]   out_data;
        logic         suppressed;
        logic         sent;
    } btp_core_t;

    btp_core_t s_q;
    btp_core_t s_d;

    // ****************************************
    // byte order helpers
    // ****************************************
    function automatic logic [31:0] le32(input logic [31:0] x);
        le32 = {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : le32

    function automatic logic [47:0] le48(input logic [47:0] x);
        le48 = {x[7:0], x[15:8], x[23:16], x[31:24], x[39:32], x[47:40]};
    endfunction : le48

    // ****************************************
    // code table
    // ****************************************
    logic [7:0] table_code;

    btp_code_table #(
        .ENTRIES (8),
        .WIDTH   (8),
        .IDX_W   (3)
    ) u_table (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (table_wr_en),
        .wr_idx  (table_wr_idx),
        .wr_data (custom_event_code_entry),
        .rd_idx  ({s_q.aux_b, s_q.aux_a, ~s_q.press}),
        .rd_data (table_code)
    );

    // ****************************************
    // substitution boxes
    // ****************************************
    logic [127:0] sub_st;
    logic [31:0]  sub_key;
    logic [31:0]  rot_word;

    assign rot_word = {s_q.rk[23:0], s_q.rk[31:24]};

    for (genvar g = 0; g < 16; g++) begin : g_state_sbox
        btp_sbox u_sbox (
            .in_byte  (s_q.aes[127-8*g -: 8]),
            .out_byte (sub_st[127-8*g -: 8])
        );
    end

    for (genvar k = 0; k < 4; k++) begin : g_key_sbox
        btp_sbox u_sbox (
            .in_byte  (rot_word[31-8*k -: 8]),
            .out_byte (sub_key[31-8*k -: 8])
        );
    end

    // ****************************************
    // ccm blocks
    // ****************************************
    logic [127:0] key_sel;
    logic [103:0] nonce;
    logic [127:0] blk_b0;
    logic [127:0] blk_b1;
    logic [127:0] blk_a0;
    logic [103:0] payload;

    assign key_sel = s_q.key_alt ? alternate_auth_key : factory_auth_key;
    assign nonce   = {le48(source_addr), le32(s_q.seq), btp_pkg::NONCE_PAD};
    assign blk_b0  = {btp_pkg::CCM_B0_FLAGS, nonce, btp_pkg::CCM_MSG_LEN};
    assign blk_a0  = {btp_pkg::CCM_A0_FLAGS, nonce, btp_pkg::CCM_CTR0};
    assign blk_b1  = {btp_pkg::AAD_LEN, btp_pkg::LEN_VALUE, btp_pkg::TYPE_MFR,
                      s_q.maker[7:0], s_q.maker[15:8], le32(s_q.seq), s_q.code,
                      btp_pkg::B1_PAD};

    // length, type, maker, counter, code, signature
    assign payload = {btp_pkg::LEN_VALUE, btp_pkg::TYPE_MFR,
                      s_q.maker[7:0], s_q.maker[15:8],
                      le32(s_q.seq),
                      s_q.code, s_q.sig};

    // ****************************************
    // one cipher round
    // ****************************************
    logic [127:0] shifted;
    logic [127:0] mixed;
    logic [127:0] next_rk;
    logic [127:0] round_out;

    always_comb begin
        logic [7:0] a0;
        logic [7:0] a1;
        logic [7:0] a2;
        logic [7:0] a3;
        logic [31:0] t;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
        a0 = 8'h00;
        a1 = 8'h00;
        a2 = 8'h00;
        a3 = 8'h00;
        t = 32'h00000000;
        w0 = 32'h00000000;
        w1 = 32'h00000000;
        w2 = 32'h00000000;
        w3 = 32'h00000000;
        shifted = '0;
        mixed = '0;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                shifted[127-8*(4*c+r) -: 8] = sub_st[127-8*(4*((c+r)%4)+r) -: 8];
            end
        end
        for (int c = 0; c < 4; c++) begin
            a0 = shifted[127-32*c -: 8];
            a1 = shifted[119-32*c -: 8];
            a2 = shifted[111-32*c -: 8];
            a3 = shifted[103-32*c -: 8];
            mixed[127-32*c -: 8] = btp_pkg::btp_xtime(a0 ^ a1) ^ a1 ^ a2 ^ a3;
            mixed[119-32*c -: 8] = btp_pkg::btp_xtime(a1 ^ a2) ^ a0 ^ a2 ^ a3;
            mixed[111-32*c -: 8] = btp_pkg::btp_xtime(a2 ^ a3) ^ a0 ^ a1 ^ a3;
            mixed[103-32*c -: 8] = btp_pkg::btp_xtime(a3 ^ a0) ^ a0 ^ a1 ^ a2;
        end
        t = sub_key ^ {s_q.rcon, 24'h000000};
        w0 = s_q.rk[127:96] ^ t;
        w1 = s_q.rk[95:64] ^ w0;
        w2 = s_q.rk[63:32] ^ w1;
        w3 = s_q.rk[31:0] ^ w2;
        next_rk = {w0, w1, w2, w3};
        round_out = ((s_q.round == btp_pkg::LAST_ROUND) ? shifted : mixed) ^ next_rk;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.suppressed = 1'b0;
        s_d.sent = 1'b0;

        // three-flop pin synchronisers, value taken once stages two and three agree
        s_d.act_sync = {s_q.act_sync[1:0], actuate};
        s_d.dir_sync = {s_q.dir_sync[1:0], harvest_dir_away};
        s_d.a_sync   = {s_q.a_sync[1:0], aux_contact_a_n};
        s_d.b_sync   = {s_q.b_sync[1:0], aux_contact_b_n};
        if (s_q.act_sync[1] == s_q.act_sync[2]) begin
            s_d.act_filt = s_q.act_sync[2];
        end
        if (s_q.dir_sync[1] == s_q.dir_sync[2]) begin
            s_d.dir_filt = s_q.dir_sync[2];
        end
        if (s_q.a_sync[1] == s_q.a_sync[2]) begin
            s_d.a_filt = s_q.a_sync[2];
        end
        if (s_q.b_sync[1] == s_q.b_sync[2]) begin
            s_d.b_filt = s_q.b_sync[2];
        end
        s_d.act_prev = s_q.act_filt;

        case (s_q.st)
            btp_pkg::ST_IDLE: begin
                if (s_q.act_filt && !s_q.act_prev) begin
                    s_d.st = btp_pkg::ST_DIR;
                end
            end
            btp_pkg::ST_DIR: begin
                s_d.press = s_q.dir_filt ^ invert_direction;
                s_d.st = btp_pkg::ST_AUX;
            end
            btp_pkg::ST_AUX: begin
                s_d.aux_a = ~s_q.a_filt;
                s_d.aux_b = ~s_q.b_filt;
                s_d.key_alt = use_alternate_key;
                s_d.maker = maker_id_field;
                s_d.st = btp_pkg::ST_LOOK;
            end
            btp_pkg::ST_LOOK: begin
                s_d.st = btp_pkg::ST_CODE;
            end
            btp_pkg::ST_CODE: begin
                if (custom_enable && table_code == btp_pkg::SUPPRESS_CODE) begin
                    s_d.suppressed = 1'b1;
                    s_d.st = btp_pkg::ST_IDLE;
                end else begin
                    if (custom_enable) begin
                        s_d.code = table_code;
                    end else begin
                        s_d.code = {btp_pkg::CODE_RSVD, s_q.aux_b, s_q.aux_a, s_q.press};
                    end
                    s_d.aes = blk_b0 ^ key_sel;
                    s_d.rk = key_sel;
                    s_d.rcon = btp_pkg::RCON_INIT;
                    s_d.round = btp_pkg::FIRST_ROUND;
                    s_d.phase = btp_pkg::PH_B0;
                    s_d.st = btp_pkg::ST_AES;
                end
            end
            btp_pkg::ST_AES: begin
                s_d.aes = round_out;
                s_d.rk = next_rk;
                s_d.rcon = btp_pkg::btp_xtime(s_q.rcon);
                s_d.round = s_q.round + 4'h1;
                if (s_q.round == btp_pkg::LAST_ROUND) begin
                    s_d.rk = key_sel;
                    s_d.rcon = btp_pkg::RCON_INIT;
                    s_d.round = btp_pkg::FIRST_ROUND;
                    case (s_q.phase)
                        btp_pkg::PH_B0: begin
                            s_d.aes = round_out ^ blk_b1 ^ key_sel;
                            s_d.phase = btp_pkg::PH_B1;
                        end
                        btp_pkg::PH_B1: begin
                            s_d.tag = round_out[127:96];
                            s_d.aes = blk_a0 ^ key_sel;
                            s_d.phase = btp_pkg::PH_A0;
                        end
                        default: begin
                            s_d.sig = s_q.tag ^ round_out[127:96];
                            s_d.idx = 4'h0;
                            s_d.out_valid = 1'b1;
                            s_d.out_data = btp_pkg::LEN_VALUE;
                            s_d.st = btp_pkg::ST_SEND;
                        end
                    endcase
                end
            end
            btp_pkg::ST_SEND: begin
                if (s_q.out_valid && out_ready) begin
                    if (s_q.idx == btp_pkg::LAST_BYTE) begin
                        s_d.out_valid = 1'b0;
                        s_d.seq = s_q.seq + 32'h00000001;
                        s_d.sent = 1'b1;
                        s_d.st = btp_pkg::ST_IDLE;
                    end else begin
                        s_d.idx = s_q.idx + 4'h1;
                        s_d.out_data = payload[(btp_pkg::PAYLOAD_BITS - 1)
                                               - 8 * int'(s_q.idx + 4'h1) -: 8];
                    end
                end
            end
            default: begin
                s_d.st = btp_pkg::ST_IDLE;
            end
        endcase

        if (!rst_n) begin
            s_d = '0;
            s_d.st = btp_pkg::ST_IDLE;
            s_d.seq = 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign out_valid  = s_q.out_valid;
    assign out_data   = s_q.out_data;
    assign out_last   = s_q.out_valid && (s_q.idx == btp_pkg::LAST_BYTE);
    assign busy       = (s_q.st != btp_pkg::ST_IDLE);
    assign suppressed = s_q.suppressed;
    assign sent       = s_q.sent;
    assign seq_count  = s_q.seq;

endmodule : btp_payload_builder

// >>> btp_pkg.sv
/*
 * shared constants, state type and byte helpers of the button telegram payload builder.
 * assumes one 200 MHz clock and a synchronous active-low reset in every user.
 */
package btp_pkg;

    // ****************************************
    // payload layout
    // ****************************************
    localparam logic [7:0]  LEN_VALUE     = 8'h0c;
    localparam logic [7:0]  TYPE_MFR      = 8'hff;
    localparam logic [7:0]  SUPPRESS_CODE = 8'hff;
    localparam logic [3:0]  LAST_BYTE     = 4'hc;
    localparam int          PAYLOAD_BITS  = 104;
    localparam logic [4:0]  CODE_RSVD     = 5'h00;

    // ****************************************
    // ccm block formatting
    // ****************************************
    localparam logic [7:0]  CCM_B0_FLAGS  = 8'h49;
    localparam logic [7:0]  CCM_A0_FLAGS  = 8'h01;
    localparam logic [15:0] CCM_MSG_LEN   = 16'h0000;
    localparam logic [15:0] CCM_CTR0      = 16'h0000;
    localparam logic [15:0] AAD_LEN       = 16'h0009;
    localparam logic [23:0] NONCE_PAD     = 24'h000000;
    localparam logic [39:0] B1_PAD        = 40'h0000000000;
    localparam logic [1:0]  PH_B0         = 2'h0;
    localparam logic [1:0]  PH_B1         = 2'h1;
    localparam logic [1:0]  PH_A0         = 2'h2;

    // ****************************************
    // block cipher
    // ****************************************
    localparam logic [3:0]  FIRST_ROUND   = 4'h1;
    localparam logic [3:0]  LAST_ROUND    = 4'ha;
    localparam logic [7:0]  RCON_INIT     = 8'h01;
    localparam logic [7:0]  GF_REDUCE     = 8'h1b;
    localparam logic [7:0]  SBOX_AFFINE   = 8'h63;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DIR,
        ST_AUX,
        ST_LOOK,
        ST_CODE,
        ST_AES,
        ST_SEND
    } btp_state_t;

    // multiply by x in the cipher field
    function automatic logic [7:0] btp_xtime(input logic [7:0] a);
        btp_xtime = {a[6:0], 1'b0} ^ (a[7] ? GF_REDUCE : 8'h00);
    endfunction : btp_xtime

endpackage : btp_pkg

// >>> btp_sbox.sv
/*
 * one byte of the cipher substitution, computed as field inverse plus affine map.
 * assumes btp_pkg is compiled first; purely combinational.
 */
`timescale 1ns/1ps
module btp_sbox (
    input  wire logic [7:0] in_byte,
    output logic      [7:0] out_byte
);

    function automatic logic [7:0] gmul(input logic [7:0] x, input logic [7:0] y);
        logic [7:0] a;
        logic [7:0] p;
        a = x;
        p = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (y[i]) begin
                p = p ^ a;
            end
            a = btp_pkg::btp_xtime(a);
        end
        return p;
    endfunction : gmul

    // ****************************************
    // inverse as x^254, then affine map
    // ****************************************
    always_comb begin
        logic [7:0] t;
        logic [7:0] inv;
        t = in_byte;
        inv = 8'h01;
        for (int k = 1; k < 8; k++) begin
            t = gmul(t, t);
            inv = gmul(inv, t);
        end
        out_byte = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]}
                 ^ {inv[4:0], inv[7:5]} ^ {inv[3:0], inv[7:4]} ^ btp_pkg::SBOX_AFFINE;
    end

endmodule : btp_sbox

// >>> btp_code_table.sv
/*
 * eight-entry event code table with a write port and a registered read.
 * assumes clk and a synchronous active-low rst_n shared with the builder.
 */
`timescale 1ns/1ps
module btp_code_table #(
    parameter int ENTRIES = 8,
    parameter int WIDTH   = 8,
    parameter int IDX_W   = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [WIDTH-1:0] rd_data
);

    if (ENTRIES != (1 << IDX_W) || WIDTH < IDX_W) begin : g_bad_size
        $error("btp_code_table: unsupported size");
    end

    typedef struct packed {
        logic [ENTRIES-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]              rd;
    } btp_table_t;

    btp_table_t s_q;
    btp_table_t s_d;

    // ****************************************
    // defaults mirror the fixed encoding
    // ****************************************
    always_comb begin
        logic [IDX_W-1:0] i_idx;
        i_idx = '0;
        s_d = s_q;
        s_d.rd = s_q.mem[rd_idx];
        if (wr_en) begin
            s_d.mem[wr_idx] = wr_data;
        end
        if (!rst_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                i_idx = IDX_W'(i);
                s_d.mem[i] = WIDTH'({i_idx[IDX_W-1:1], ~i_idx[0]});
            end
            s_d.rd = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign rd_data = s_q.rd;

endmodule : btp_code_table

// >>> btp_payload_builder_chk.sv
/*
 * port assertions of the payload builder, bound into btp_payload_builder.
 * assumes clk with a synchronous active-low rst_n and the builder's port names.
 */
`timescale 1ns/1ps
module btp_payload_builder_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] maker_id_field,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [7:0]  out_data,
    input wire logic        out_last,
    input wire logic        busy,
    input wire logic        suppressed,
    input wire logic        sent,
    input wire logic [31:0] seq_count
);
    // ****************************************
    // byte position tracker
    // ****************************************
    logic [3:0] idx_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_q <= 4'h0;
        end else if (out_valid && out_ready) begin
            idx_q <= out_last ? 4'h0 : idx_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_len_first: assert property (out_valid && idx_q == 4'h0 |-> out_data == 8'h0c)
        else $error("length byte wrong");
    chk_type_byte: assert property (out_valid && idx_q == 4'h1 |-> out_data == 8'hff)
        else $error("type byte wrong");
    chk_maker_bytes: assert property (out_valid && idx_q inside {4'h2, 4'h3} |->
        out_data == (idx_q == 4'h2 ? maker_id_field[7:0] : maker_id_field[15:8]))
        else $error("maker byte wrong");
    chk_seq_bytes: assert property (out_valid && idx_q >= 4'h4 && idx_q <= 4'h7 |->
        out_data == 8'(seq_count >> {idx_q - 4'h4, 3'h0}))
        else $error("counter byte wrong");
    chk_last_pos: assert property (out_valid |-> out_last == (idx_q == 4'hc))
        else $error("last flag misplaced");
    chk_stall_hold: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data) && $stable(out_last))
        else $error("byte dropped during stall");
    chk_sent_count: assert property (out_valid && out_ready && out_last |=>
        sent && seq_count == $past(seq_count) + 32'h1)
        else $error("counter not advanced");
    chk_count_cause: assert property (seq_count != $past(seq_count) |-> sent)
        else $error("counter moved without telegram");
    chk_drop_quiet: assert property (suppressed |-> !out_valid && $stable(seq_count))
        else $error("dropped telegram had effect");
    chk_busy_answer: assert property ($rose(busy) |-> ##[4:34] (out_valid || suppressed))
        else $error("no answer after actuation");
endmodule : btp_payload_builder_chk

bind btp_payload_builder btp_payload_builder_chk u_chk (
    .clk(clk), .rst_n(rst_n), .maker_id_field(maker_id_field),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_last(out_last), .busy(busy), .suppressed(suppressed),
    .sent(sent), .seq_count(seq_count));

// >>> btp_rx_model.sv
/*
 * receiver model: takes the byte stream, checks signature and counter freshness.
 * assumes the builder's stream handshake; keeps its memory across builder resets.
 */
`timescale 1ns/1ps
module btp_rx_model (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [7:0]  out_data,
    input  wire logic        out_last,
    input  wire logic        ref_en,
    input  wire logic [31:0] ref_sig,
    output logic             out_ready,
    output logic             rx_done,
    output logic [7:0]       rx_code,
    output logic [31:0]      rx_sig,
    output logic             rx_sig_ok,
    output logic             rx_accept
);
    logic [103:0] p;
    logic [31:0]  seq;
    logic [31:0]  last_q = 32'h0;
    logic         seen_q = 1'b0;
    logic [1:0]   ph_q = 2'h0;
    logic         ok;
    initial begin
        out_ready = 1'b1;
        rx_done = 1'b0;
    end
    always @(posedge clk) begin
        rx_done <= 1'b0;
        ph_q <= ph_q + 2'h1;
        out_ready <= !stall || ph_q[0];
        if (out_valid && out_ready) begin
            p = {p[95:0], out_data};
            if (out_last) begin
                seq = {p[47:40], p[55:48], p[63:56], p[71:64]};
                ok = p[103:88] == 16'h0cff && (!ref_en || p[31:0] == ref_sig);
                if (ok && (!seen_q || seq > last_q)) begin
                    seen_q <= 1'b1;
                    last_q <= seq;
                end
                rx_accept <= ok && (!seen_q || seq > last_q);
                rx_sig_ok <= ok;
                rx_code <= p[39:32];
                rx_sig <= p[31:0];
                rx_done <= 1'b1;
            end
        end
    end
endmodule : btp_rx_model

// >>> btp_payload_builder_tb.sv
/*
 * self-checking bench of the payload builder with a receiver model on its stream.
 * assumes btp_pkg, the builder, its checker and btp_rx_model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module btp_payload_builder_tb;
    typedef struct packed { logic [3:0] pins; logic [7:0] code; } btp_row_t;
    logic         clk = 1'b0, rst_n = 1'b0, actuate = 1'b0, stall = 1'b0;
    logic         dir_away = 1'b0, invert = 1'b0, a_n = 1'b1, b_n = 1'b1;
    logic         custom_en = 1'b0, alt_key = 1'b0, wr_en = 1'b0, ref_en = 1'b0;
    logic [2:0]   wr_idx = 3'h0;
    logic [7:0]   wr_data = 8'h00, out_data, rx_code;
    logic [31:0]  seq_count, rx_sig, sig0 = 32'h0, ref_sig = 32'h0;
    logic         out_valid, out_ready, out_last, busy, suppressed, sent;
    logic         rx_done, rx_sig_ok, rx_accept, sup;
    int           checks = 0, failures = 0;
    btp_row_t     rows [10] = '{'{4'hb, 8'h01}, '{4'h3, 8'h00}, '{4'h9, 8'h03},
        '{4'h1, 8'h02}, '{4'ha, 8'h05}, '{4'h2, 8'h04}, '{4'h8, 8'h07},
        '{4'h0, 8'h06}, '{4'h7, 8'h01}, '{4'hc, 8'h06}};
    always #2.5 clk = ~clk;
    btp_payload_builder DUT (
        .clk(clk), .rst_n(rst_n), .actuate(actuate), .harvest_dir_away(dir_away),
        .aux_contact_a_n(a_n), .aux_contact_b_n(b_n), .invert_direction(invert),
        .custom_enable(custom_en), .use_alternate_key(alt_key),
        .maker_id_field(16'h5a17), .source_addr(48'hc0de_1234_5678),
        .factory_auth_key({8{16'h1f2e}}), .alternate_auth_key({8{16'h9a8b}}),
        .table_wr_en(wr_en), .table_wr_idx(wr_idx), .custom_event_code_entry(wr_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_last(out_last), .busy(busy), .suppressed(suppressed), .sent(sent),
        .seq_count(seq_count));
    btp_rx_model u_rx (
        .clk(clk), .stall(stall), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .ref_en(ref_en), .ref_sig(ref_sig), .out_ready(out_ready),
        .rx_done(rx_done), .rx_code(rx_code), .rx_sig(rx_sig), .rx_sig_ok(rx_sig_ok),
        .rx_accept(rx_accept));
    // ****************************************
    // tasks
    // ****************************************
    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK("seq_count", 32'h0, seq_count)
        `CHK("busy", 1'b0, busy)
    endtask : do_reset
    task automatic send(input logic [3:0] pins);
        int n;
        @(posedge clk);
        {dir_away, invert, a_n, b_n} <= pins;
        repeat (4) @(posedge clk);
        actuate <= 1'b1;
        sup = 1'b0;
        for (n = 0; n < 400 && !rx_done && !sup; n++) begin
            @(posedge clk);
            #1;
            sup = suppressed;
        end
        if (n == 400) begin
            failures++;
            stop_test();
        end
        @(posedge clk);
        actuate <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : send
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        do_reset();
        for (int i = 0; i < 10; i++) begin
            stall <= i[0];
            send(rows[i].pins);
            `CHK("event_code", rows[i].code, rx_code)
            `CHK("accepted", 1'b1, rx_accept)
            `CHK("seq_count", 32'(i + 1), seq_count)
            if (i == 0) sig0 = rx_sig;
        end
        @(posedge clk);
        wr_en <= 1'b1;
        wr_idx <= 3'h1;
        wr_data <= 8'hfe;
        @(posedge clk);
        wr_idx <= 3'h0;
        wr_data <= 8'hff;
        @(posedge clk);
        wr_en <= 1'b0;
        custom_en <= 1'b1;
        send(4'h8);
        `CHK("default_entry", 8'h07, rx_code)
        send(4'h3);
        `CHK("custom_entry", 8'hfe, rx_code)
        send(4'hb);
        `CHK("suppressed", 1'b1, sup)
        `CHK("seq_count", 32'hc, seq_count)
        custom_en <= 1'b0;
        do_reset();
        ref_en <= 1'b1;
        ref_sig <= sig0;
        send(4'hb);
        `CHK("same_sig", sig0, rx_sig)
        `CHK("sig_ok", 1'b1, rx_sig_ok)
        `CHK("replay_refused", 1'b0, rx_accept)
        do_reset();
        alt_key <= 1'b1;
        send(4'hb);
        `CHK("alt_sig_differs", 1'b1, rx_sig !== sig0)
        `CHK("alt_sig_ok", 1'b0, rx_sig_ok)
        stop_test();
    end
endmodule : btp_payload_builder_tb
